/* rtl/lcd_bias_pkg.sv */
package lcd_bias_pkg;

  // Register map, byte addresses on a 32-bit Wishbone slave.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] OFS_ENABLE = 8'h00;
  localparam logic [7:0] OFS_FRAME = 8'h04;
  localparam logic [7:0] OFS_BIAS = 8'h08;
  localparam logic [7:0] OFS_PIXEL_COLUMN_0 = 8'h0c;
  localparam logic [7:0] SEG_STRIDE = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h5c;

  // Field positions and layouts.
  localparam int ENABLE_BIT = 0;
  localparam int SRC_BIT = 3;
  localparam int HIGH_BIT = 4;
  localparam int LOW_LSB = 5;
  localparam int LOW_MSB = 7;
  localparam int FRAME_W = 4;
  localparam int BYTE_W = 8;
  localparam int NIB_W = 4;
  localparam int N_WORDS = 2;
  localparam int STAT_CONN = 0;
  localparam int STAT_TIMED = 1;
  localparam int STAT_FRAME = 2;
  localparam logic [7:0] BIAS_MASK = 8'hf8;

  // Reset values.
  localparam logic [7:0] BIAS_RESET = 8'h00;
  localparam logic [7:0] SEG_RESET = 8'h00;
  localparam logic [3:0] FRAME_RESET = 4'h0;

  // Low bleeder time codes and frame base codes.
  localparam logic [2:0] LOW_NEVER = 3'h0;
  localparam logic [2:0] LOW_ALWAYS = 3'h6;
  localparam logic [2:0] LOW_RSVD = 3'h7;
  localparam logic [3:0] FRAME_SYS_LAST = 4'h4;
  localparam logic [3:0] FRAME_LS_A = 4'h8;
  localparam logic [3:0] FRAME_LS_B = 4'h9;

  // Divider and duration exponents.
  localparam logic [4:0] SYS_DIV_TOP = 5'h12;
  localparam logic [4:0] LS_DIV_A = 5'h09;
  localparam logic [4:0] LS_DIV_B = 5'h08;
  localparam logic [4:0] SYS_LOW_TOP = 5'h0a;
  localparam int CNT_W_MIN = 16;

  typedef enum logic [1:0] {CONN_OFF, CONN_TIMED, CONN_HOLD} conn_state_t;

  function automatic logic frame_is_sys(input logic [3:0] f);
    return f <= FRAME_SYS_LAST;
  endfunction

  function automatic logic frame_valid(input logic [3:0] f);
    return frame_is_sys(f) || f == FRAME_LS_A || f == FRAME_LS_B;
  endfunction

  // Base frame divider exponent; zero for a reserved code.
  function automatic logic [4:0] frame_div_exp(input logic [3:0] f);
    if (frame_is_sys(f)) return SYS_DIV_TOP - {1'b0, f};
    else if (f == FRAME_LS_A) return LS_DIV_A;
    else if (f == FRAME_LS_B) return LS_DIV_B;
    else return 5'h00;
  endfunction

  // Low resistance connection exponent for a timed code.
  function automatic logic [4:0] low_time_exp(input logic [2:0] k,
                                              input logic [3:0] f);
    logic [4:0] e;
    e = 5'h00;
    if (frame_is_sys(f)) e = SYS_LOW_TOP + {2'h0, k} - {1'b0, f};
    else if (f == FRAME_LS_A) e = {2'h0, k} + 5'h01;
    else if (f == FRAME_LS_B) begin
      case (k)
        3'h1: e = 5'h01;
        3'h2: e = 5'h02;
        3'h3: e = 5'h02;
        3'h4: e = 5'h04;
        default: e = 5'h05;
      endcase
    end
    return e;
  endfunction

  function automatic logic low_code_timed(input logic [2:0] k);
    return k != LOW_NEVER && k < LOW_ALWAYS;
  endfunction

endpackage

/* rtl/frame_divider.sv */
`timescale 1ns/100ps
module frame_divider
  import lcd_bias_pkg::*;
#(
  parameter int DIV_W = 18
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [3:0] frame_sel,
  input wire logic low_speed_clock,
  output logic base_tick_q,
  output logic period_tick
);

  if (DIV_W < int'(SYS_DIV_TOP)) begin : g_bad_width
    $error("frame_divider: DIV_W too small for the slowest frame");
  end

  logic lsc_q;
  logic [DIV_W-1:0] cnt_q;
  logic [DIV_W-1:0] mask;
  logic [DIV_W:0] gap_q;
  logic steady_q;

  // The slow clock is sampled as a level; its rising edge is one period.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) lsc_q <= 1'b0;
    else lsc_q <= low_speed_clock;
  end

  assign period_tick = run && (frame_is_sys(frame_sel) ||
                       (low_speed_clock && !lsc_q));
  assign mask = (DIV_W'(1) << frame_div_exp(frame_sel)) - DIV_W'(1);

  // Free-running prescaler; frozen while the driver is disabled.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) cnt_q <= '0;
    else if (period_tick) cnt_q <= cnt_q + DIV_W'(1); // RULE9
  end

  // A reserved frame code never produces a tick.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) base_tick_q <= 1'b0;
    else base_tick_q <= period_tick && frame_valid(frame_sel) && // RULE8
                        (cnt_q & mask) == mask;
  end

  // Helper for the spacing check below.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gap_q <= '0;
      steady_q <= 1'b0;
    end else begin
      gap_q <= base_tick_q ? '0 : gap_q + (DIV_W+1)'(1);
      steady_q <= base_tick_q || (steady_q && run &&
                  frame_is_sys(frame_sel) && $stable(frame_sel));
    end
  end

  chk_sys_frame_gap: assert property (@(posedge sys_clk) disable iff (rst) // RULE8
    base_tick_q && steady_q && run && frame_is_sys(frame_sel)
    |-> gap_q == {1'b0, mask})
    else $error("frame tick spacing differs from the divider setting");

endmodule // frame_divider

/* rtl/bleeder_timer.sv */
`timescale 1ns/100ps
module bleeder_timer
  import lcd_bias_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic run,
  input wire logic internal_sel,
  input wire logic [2:0] low_code,
  input wire logic [3:0] frame_sel,
  input wire logic level_change,
  input wire logic period_tick,
  output logic low_connect_q,
  output logic timed_busy
);

  if (CNT_W < CNT_W_MIN) begin : g_bad_width
    $error("bleeder_timer: CNT_W cannot hold the longest connection");
  end

  conn_state_t state_q, state_d;
  logic [CNT_W-1:0] cnt_q;
  logic load;

  assign load = run && state_d == CONN_TIMED && level_change;
  assign timed_busy = state_q == CONN_TIMED;

  // Next state; external mode forces the low network off.
  always_comb begin
    state_d = state_q;
    if (!run) state_d = state_q; // RULE9
    else if (!internal_sel || low_code == LOW_NEVER ||
             low_code == LOW_RSVD) state_d = CONN_OFF; // RULE1 RULE5
    else if (low_code == LOW_ALWAYS) state_d = CONN_HOLD; // RULE1
    else begin
      case (state_q)
        CONN_TIMED: begin
          if (level_change) state_d = CONN_TIMED; // RULE10
          else if (period_tick && cnt_q == CNT_W'(1)) state_d = CONN_OFF;
        end
        default: begin
          if (level_change && frame_valid(frame_sel))
            state_d = CONN_TIMED; // RULE10
          else state_d = CONN_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) state_q <= CONN_OFF;
    else state_q <= state_d;
  end

  // Each drive level change restarts the full count of periods.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) cnt_q <= '0;
    else if (load)
      cnt_q <= CNT_W'(1) << low_time_exp(low_code, frame_sel); // RULE2 RULE3
    else if (run && state_q == CONN_TIMED && period_tick)
      cnt_q <= cnt_q - CNT_W'(1);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) low_connect_q <= 1'b0;
    else low_connect_q <= state_d != CONN_OFF;
  end

  sequence timed_start(logic [2:0] k, logic [3:0] f);
    run && internal_sel && low_code == k && frame_sel == f && level_change;
  endsequence

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  chk_sys_first_load: assert property ( // RULE2
    timed_start(3'h1, 4'h0) |=> cnt_q == CNT_W'(16'h0800))
    else $error("code 1 at frame 0 did not load 2048 periods");
  // The fastest system frame is the one a short run can reach.
  chk_sys_fast_load: assert property ( // RULE2
    timed_start(3'h1, 4'h4) |=> cnt_q == CNT_W'(16'h0080))
    else $error("code 1 at frame 4 did not load 128 periods");
  chk_ls_odd_load: assert property ( // RULE3
    timed_start(3'h3, 4'h9) |=> cnt_q == CNT_W'(16'h0004))
    else $error("code 3 at slow frame 9 did not load 4 periods");
  chk_ls_even_load: assert property ( // RULE3
    timed_start(3'h5, 4'h8) |=> cnt_q == CNT_W'(16'h0040))
    else $error("code 5 at slow frame 8 did not load 64 periods");
  chk_timed_end: assert property ( // RULE2
    run && internal_sel && low_code_timed(low_code) && timed_busy &&
    period_tick && cnt_q == CNT_W'(1) && !level_change
    |=> !low_connect_q)
    else $error("low network stayed on after its count");
  chk_start_change: assert property ( // RULE10
    run && internal_sel && low_code_timed(low_code) &&
    frame_valid(frame_sel) && level_change
    |=> low_connect_q && timed_busy)
    else $error("level change did not start a timed connection");
  chk_never_code: assert property ( // RULE1
    run && low_code == LOW_NEVER |=> !low_connect_q)
    else $error("low network connected with code 0");
  chk_always_code: assert property ( // RULE1
    run && internal_sel && low_code == LOW_ALWAYS |=> low_connect_q)
    else $error("low network not held with code 6");

endmodule // bleeder_timer

/* rtl/lcd_bias_and_segment_buffer.sv */
// Implementation choices: the Wishbone slave port and the register addresses.
`timescale 1ns/100ps
// Function
// RULE1: code 0 never, 6 always, 7 reserved.
// RULE2: system frames hold low network 2^(10+k-s) clocks.
// RULE3: slow frames 8/9 use the slow-clock duration table.
// RULE4: source bit 3 picks external or internal network.
// RULE5: time and high value act only when internal.
// RULE6: word 0 holds columns 1 and 0.
// RULE7: word 1 holds columns 3 and 2.
// RULE8: frame base divides system or slow clock.
// RULE9: disabled driver freezes and keeps every register. The enable bit stays writable while disabled.
// RULE10: timed connection starts at each level change.
module lcd_bias_and_segment_buffer
  import lcd_bias_pkg::*;
#(
  parameter int DIV_W = 18,
  parameter int CNT_W = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [DATA_W-1:0] wb_dat_i,
  output logic [DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic low_speed_clock,
  output logic driver_enable,
  output logic frame_base_tick,
  output logic bleeder_source_sel,
  output logic high_bleeder_value_sel,
  output logic low_bleeder_connect,
  output logic [NIB_W-1:0] pixel_column_0,
  output logic [NIB_W-1:0] pixel_column_1,
  output logic [NIB_W-1:0] pixel_column_2,
  output logic [NIB_W-1:0] pixel_column_3
);

  logic ack_q;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic enable_q;
  logic [FRAME_W-1:0] frame_sel_q;
  logic [BYTE_W-1:0] bias_q;
  logic [N_WORDS-1:0][BYTE_W-1:0] seg_q;
  logic high_q;
  logic req;
  logic wr_ok;
  logic period_tick;
  logic timed_busy;

  // A write lands on the edge where the master sees ack.
  function automatic logic wr_at(input logic [ADDR_W-1:0] ofs);
    return wr_ok && wb_adr_i == ofs;
  endfunction

  assign req = wb_cyc_i && wb_stb_i;
  assign wr_ok = req && wb_we_i && ack_q && wb_sel_i[0];
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;
  assign driver_enable = enable_q;
  assign bleeder_source_sel = bias_q[SRC_BIT]; // RULE4
  assign high_bleeder_value_sel = high_q;
  assign pixel_column_0 = seg_q[0][NIB_W-1:0]; // RULE6
  assign pixel_column_1 = seg_q[0][BYTE_W-1:NIB_W]; // RULE6
  assign pixel_column_2 = seg_q[1][NIB_W-1:0]; // RULE7
  assign pixel_column_3 = seg_q[1][BYTE_W-1:NIB_W]; // RULE7

  // One wait state; ack drops the cycle after it was given, so a
  // held request is answered again every second cycle.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) ack_q <= 1'b0;
    else ack_q <= req && !ack_q;
  end

  // The enable bit itself stays writable so software can wake the
  // block; everything else is ignored while it is low.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) enable_q <= 1'b0;
    else if (wr_at(OFS_ENABLE)) enable_q <= wb_dat_i[ENABLE_BIT];
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) frame_sel_q <= FRAME_RESET;
    else if (enable_q && wr_at(OFS_FRAME)) // RULE9
      frame_sel_q <= wb_dat_i[FRAME_W-1:0];
  end

  // Bits 2..0 of the bias word are not stored and read as zero.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) bias_q <= BIAS_RESET;
    else if (enable_q && wr_at(OFS_BIAS)) // RULE9
      bias_q <= wb_dat_i[BYTE_W-1:0] & BIAS_MASK; // RULE4
  end

  // The high value select is ignored in external mode.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) high_q <= 1'b0;
    else if (enable_q) high_q <= bias_q[SRC_BIT] && bias_q[HIGH_BIT]; // RULE5
  end

  // Segment data words, one byte each, two nibbles per word.
  for (genvar w = 0; w < N_WORDS; w++) begin : g_seg
    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) seg_q[w] <= SEG_RESET;
      else if (enable_q &&
               wr_at(ADDR_W'(OFS_PIXEL_COLUMN_0 + SEG_STRIDE * w))) // RULE6 RULE7
        seg_q[w] <= wb_dat_i[BYTE_W-1:0];
    end
  end

  // Read mux; unmapped addresses and unused bits read as zero.
  always_comb begin
    rdata_d = '0;
    case (wb_adr_i)
      OFS_ENABLE: rdata_d[ENABLE_BIT] = enable_q;
      OFS_FRAME: rdata_d[FRAME_W-1:0] = frame_sel_q;
      OFS_BIAS: rdata_d[BYTE_W-1:0] = bias_q;
      OFS_PIXEL_COLUMN_0: rdata_d[BYTE_W-1:0] = seg_q[0]; // RULE6
      OFS_PIXEL_COLUMN_0 + SEG_STRIDE: rdata_d[BYTE_W-1:0] = seg_q[1]; // RULE7
      OFS_STATUS: begin
        rdata_d[STAT_CONN] = low_bleeder_connect;
        rdata_d[STAT_TIMED] = timed_busy;
        rdata_d[STAT_FRAME] = frame_valid(frame_sel_q);
      end
      default: rdata_d = '0;
    endcase
  end

  // Read data is captured with ack and held until the next read.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) rdata_q <= '0;
    else if (req && !ack_q && !wb_we_i) rdata_q <= rdata_d;
  end

  // Frame base and period source for the bleeder timer.
  frame_divider #(
    .DIV_W(DIV_W)
  ) u_divider (
    .sys_clk(sys_clk),
    .rst(rst),
    .run(enable_q),
    .frame_sel(frame_sel_q),
    .low_speed_clock(low_speed_clock),
    .base_tick_q(frame_base_tick),
    .period_tick(period_tick)
  );

  // Each frame tick is a change of drive levels on the glass.
  bleeder_timer #(
    .CNT_W(CNT_W)
  ) u_timer (
    .sys_clk(sys_clk),
    .rst(rst),
    .run(enable_q),
    .internal_sel(bias_q[SRC_BIT]),
    .low_code(bias_q[LOW_MSB:LOW_LSB]),
    .frame_sel(frame_sel_q),
    .level_change(frame_base_tick),
    .period_tick(period_tick),
    .low_connect_q(low_bleeder_connect),
    .timed_busy(timed_busy)
  );

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  chk_source_route: assert property ( // RULE4
    enable_q && wr_at(OFS_BIAS)
    |=> bleeder_source_sel == $past(wb_dat_i[SRC_BIT]))
    else $error("source select did not follow the written bit");
  chk_external_quiet: assert property ( // RULE5
    (!bleeder_source_sel && enable_q) [*2]
    |-> !high_bleeder_value_sel && !low_bleeder_connect)
    else $error("internal network active in external mode");
  // The high value output follows the stored bits one cycle later.
  chk_high_follow: assert property ( // RULE5
    enable_q
    |=> high_bleeder_value_sel == $past(bias_q[SRC_BIT] && bias_q[HIGH_BIT]))
    else $error("high value select does not follow the bias word");
  chk_word0_read: assert property ( // RULE6
    req && !wb_we_i && !ack_q && wb_adr_i == OFS_PIXEL_COLUMN_0
    |=> wb_ack_o && wb_dat_o == DATA_W'({pixel_column_1, pixel_column_0}))
    else $error("word 0 read does not show columns 1 and 0");
  chk_word1_read: assert property ( // RULE7
    req && !wb_we_i && !ack_q && wb_adr_i == OFS_PIXEL_COLUMN_0 + SEG_STRIDE
    |=> wb_ack_o && wb_dat_o == DATA_W'({pixel_column_3, pixel_column_2}))
    else $error("word 1 read does not show columns 3 and 2");
  chk_disabled_hold: assert property ( // RULE9
    !enable_q |=> $stable(bias_q) && $stable(seg_q) &&
    $stable(frame_sel_q) && $stable(low_bleeder_connect))
    else $error("state changed while the driver was disabled");

endmodule // lcd_bias_and_segment_buffer

/* verification/lcd_panel_model.sv */
`timescale 1ns/100ps
module lcd_panel_model (
  input wire logic sys_clk,
  input wire logic rst,
  output logic low_speed_clock
);
  // The slow clock is four system periods long and runs free, so slow-frame
  // durations in system cycles carry up to one slow period of phase error.
  logic [1:0] div_q;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      div_q <= 2'h0;
    end else begin
      div_q <= div_q + 2'h1;
    end
  end
  assign low_speed_clock = div_q[1];
endmodule // lcd_panel_model

/* verification/testbench.sv */
`timescale 1ns/100ps
module testbench;
  import lcd_bias_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic req = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hf;
  logic [31:0] dat = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, low_speed_clock, driver_enable, frame_base_tick;
  logic bleeder_source_sel, high_bleeder_value_sel, low_bleeder_connect;
  logic [3:0] pixel_column_0, pixel_column_1, pixel_column_2, pixel_column_3;
  int num_errors = 0;
  int tests_run = 0;
  logic [31:0] rd, r;
  logic [7:0] seg [2];
  logic [7:0] v;
  int gap, width, e;

  // Free-running system clock.
  always #12.5 sys_clk = ~sys_clk;

  lcd_bias_and_segment_buffer DUT (.sys_clk(sys_clk), .rst(rst),
    .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .low_speed_clock(low_speed_clock),
    .driver_enable(driver_enable), .frame_base_tick(frame_base_tick),
    .bleeder_source_sel(bleeder_source_sel),
    .high_bleeder_value_sel(high_bleeder_value_sel),
    .low_bleeder_connect(low_bleeder_connect),
    .pixel_column_0(pixel_column_0), .pixel_column_1(pixel_column_1),
    .pixel_column_2(pixel_column_2), .pixel_column_3(pixel_column_3));

  lcd_panel_model panel (.sys_clk(sys_clk), .rst(rst),
    .low_speed_clock(low_speed_clock));

  // One classic cycle; the request stands until ack is sampled high.
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge sys_clk);
    req <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    if (n >= 50) num_errors++;
    req <= 1'b0;
  endtask

  task automatic chk_span(input string nm, input logic [31:0] lo,
                          input logic [31:0] hi, input logic [31:0] got);
    tests_run++;
    if (!((got >= lo) === 1'b1 && (got <= hi) === 1'b1)) begin
      num_errors++;
      $display("ERROR %s expected %0h..%0h seen %0h", nm, lo, hi, got);
    end
  endtask

  task automatic chk_reg(input string nm, input logic [31:0] ex,
                         input logic [31:0] got);
    chk_span(nm, ex, ex, got);
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a,
                        input logic [31:0] ex);
    wb(1'b0, a, 32'h0, rd);
    chk_reg(nm, ex, rd);
  endtask

  // Waits for a frame tick, then counts the gap to the next tick and the
  // cycles with the low network connected in between.
  task automatic measure(output int g, output int w);
    int n;
    n = 0;
    g = 0;
    w = 0;
    do begin
      @(posedge sys_clk);
      #1 n++;
    end while (frame_base_tick !== 1'b1 && n < 40000);
    do begin
      @(posedge sys_clk);
      #1 g++;
      if (low_bleeder_connect === 1'b1) w++;
    end while (frame_base_tick !== 1'b1 && g < 40000);
    // A missing frame tick is a fault even when no width is expected.
    if (n >= 40000 || g >= 40000) num_errors++;
  endtask

  // Duration exponent of a timed code for a given frame base code.
  function automatic int dur_exp(input int k, input int f);
    int t9[5] = '{1, 2, 2, 4, 5};
    if (f <= 4) return 10 + k - f;
    if (f == 8) return k + 1;
    return t9[k-1];
  endfunction

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // A hung handshake or a missing tick must not stall the run.
  initial begin
    repeat (90000) @(posedge sys_clk);
    num_errors++;
    finish_test();
  end

  initial begin
    void'($urandom(32'ha68e));
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    rd_chk("bias reset", OFS_BIAS, 32'h0);
    rd_chk("word0 reset", OFS_PIXEL_COLUMN_0, 32'h0);
    rd_chk("word1 reset", OFS_PIXEL_COLUMN_0 + SEG_STRIDE, 32'h0);
    rd_chk("unmapped", 8'h40, 32'h0);
    wb(1'b1, OFS_PIXEL_COLUMN_0, 32'h5a, rd);
    rd_chk("write while off", OFS_PIXEL_COLUMN_0, 32'h0);
    wb(1'b1, OFS_ENABLE, 32'h1, rd);
    // Random segment data; upper bits of the bus must read back as zero.
    for (int i = 0; i < 8; i++) begin
      for (int j = 0; j < 2; j++) begin
        r = $urandom();
        wb(1'b1, OFS_PIXEL_COLUMN_0 + (j ? SEG_STRIDE : 8'h00), r, rd);
        seg[j] = r[7:0];
        rd_chk("word", OFS_PIXEL_COLUMN_0 + (j ? SEG_STRIDE : 8'h00), {24'h0, r[7:0]});
      end
      chk_reg("column0", {28'h0, seg[0][3:0]}, {28'h0, pixel_column_0});
      chk_reg("column1", {28'h0, seg[0][7:4]}, {28'h0, pixel_column_1});
      chk_reg("column2", {28'h0, seg[1][3:0]}, {28'h0, pixel_column_2});
      chk_reg("column3", {28'h0, seg[1][7:4]}, {28'h0, pixel_column_3});
    end
    // A write without byte lane 0 must leave the word untouched.
    sel <= 4'he;
    wb(1'b1, OFS_PIXEL_COLUMN_0, {24'h0, ~seg[0]}, rd);
    sel <= 4'hf;
    rd_chk("lane off", OFS_PIXEL_COLUMN_0, {24'h0, seg[0]});
    chk_reg("enable", 32'h1, {31'h0, driver_enable});
    // Every combination of time code, high value and source.
    for (int b = 0; b < 32; b++) begin
      r = $urandom();
      v = {b[4:0], r[2:0]};
      wb(1'b1, OFS_BIAS, {24'h0, v}, rd);
      rd_chk("bias", OFS_BIAS, {24'h0, v & BIAS_MASK});
      chk_reg("source", {31'h0, v[3]}, {31'h0, bleeder_source_sel});
      chk_reg("high", {31'h0, v[3] & v[4]}, {31'h0, high_bleeder_value_sel});
    end
    // Disabling keeps contents; they read back unchanged while still disabled.
    wb(1'b1, OFS_ENABLE, 32'h0, rd);
    rd_chk("kept word0", OFS_PIXEL_COLUMN_0, {24'h0, seg[0]});
    chk_reg("kept column3", {28'h0, seg[1][7:4]}, {28'h0, pixel_column_3});
    chk_reg("disabled", 32'h0, {31'h0, driver_enable});
    wb(1'b1, OFS_ENABLE, 32'h1, rd);
    // Fastest system frame with the shortest timed code.
    wb(1'b1, OFS_FRAME, 32'h4, rd);
    wb(1'b1, OFS_BIAS, 32'h28, rd);
    measure(gap, width);
    chk_reg("sys gap", 32'd16384, gap);
    chk_reg("sys width", 32'd128, width);
    // Slow frames over every timed code.
    for (int f = 8; f <= 9; f++) begin
      wb(1'b1, OFS_FRAME, f, rd);
      for (int k = 1; k <= 5; k++) begin
        r = $urandom();
        wb(1'b1, OFS_BIAS, {24'h0, k[2:0], r[0], 4'h8}, rd);
        measure(gap, width);
        e = (f == 8) ? 2048 : 1024;
        chk_span("slow gap", e - 5, e + 5, gap);
        e = 4 << dur_exp(k, f);
        chk_span("slow width", e - 5, e + 5, width);
      end
    end
    // Never, always, reserved, and a timed code in external mode.
    for (int c = 0; c < 4; c++) begin
      v = (c == 0) ? 8'h08 : (c == 1) ? 8'hc8 : (c == 2) ? 8'he8 : 8'h20;
      wb(1'b1, OFS_BIAS, {24'h0, v}, rd);
      measure(gap, width);
      e = (c == 1) ? 1024 : 0;
      chk_span("fixed width", e - (e ? 5 : 0), e + (e ? 5 : 0), width);
      rd_chk("status", OFS_STATUS, (c == 1) ? 32'h5 : 32'h4);
    end
    finish_test();
  end
endmodule // testbench
